// [include/ofsc_cfg.svh]
`ifndef OFSC_CFG_SVH
`define OFSC_CFG_SVH

// ************************************************************
// Register offsets on the byte-wide register port
// ************************************************************
`define OFSC_REFCLK_ADDR 8'h00
`define OFSC_OSC_ADDR 8'h01
`define OFSC_CFG_ADDR 8'h02
`define OFSC_IRQ_STAT_ADDR 8'h03
`define OFSC_IRQ_CLR_ADDR 8'h04
`define OFSC_IRQ_EN_ADDR 8'h05

// ************************************************************
// Field positions and reset values
// ************************************************************
`define OFSC_ROE_BIT 6
`define OFSC_FSEL_MSB 6
`define OFSC_FSEL_LSB 4
`define OFSC_HFR_BIT 3
`define OFSC_LFR_BIT 1
`define OFSC_HFS_BIT 0
`define OFSC_EXT_BIT 0
`define OFSC_FSEL_RST 3'h6
`define OFSC_FSEL_16M 3'h7
`define OFSC_FSEL_LF 3'h0
`define OFSC_ROE_RST 1'h0
`define OFSC_EXT_RST 1'h0

`endif

// [include/ofsc_pkg.sv]
package ofsc_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    // Oscillator start-up sequence
    typedef enum logic [1:0] {
        OFSC_ST_IDLE = 2'b00,
        OFSC_ST_SEC = 2'b01,
        OFSC_ST_PRI = 2'b10,
        OFSC_ST_RUN = 2'b11
    } ofsc_hf_st_t;

    // Status reported by the analog oscillators
    typedef struct packed {
        logic hf_sec_ready;
        logic hf_pri_stable;
        logic lf_ready;
    } ofsc_osc_stat_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ofsc_bus_req_t;

endpackage : ofsc_pkg

// [design/ofsc_ctrl.sv]
// The implementer's own choices: the register addresses and strobed register access.
`include "ofsc_cfg.svh"

// What this block does
// R1: Enable bit 6 set drives system clock onto reference pin, ignoring direction.
// R2: Select field bits 6-4: 111 is 16 MHz, halving down, 000 is 31 kHz.
// R3: After reset the select field holds 110, giving 8 MHz.
// R4: Read-only bit 3 shows high-frequency oscillator ready.
// R5: Read-only bit 1 shows low-frequency oscillator ready.
// R6: Read-only bit 0 shows high-frequency oscillator stable.
// R7: Unimplemented bits of both control registers read as zero.
// R8: External clock mode uses the logic-level clock on the input pin.
// R9: Source bit clear selects internal oscillator and frees the input pin.
// R10: Fast secondary clock starts first, then accurate primary clock.
// R11: Changing between high-frequency rates takes effect with no delay.
// R12: Reset clears output enable and all three oscillator flags.
module ofsc_ctrl (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire ofsc_pkg::ofsc_bus_req_t bus, // Register port request
    output logic [7:0] rdata_r, // Read data, cycle after read
    input wire ofsc_pkg::ofsc_osc_stat_t osc, // Analog oscillator status
    input wire logic hf_osc_in, // 16 MHz oscillator waveform
    input wire logic lf_osc_in, // 31 kHz oscillator waveform
    input wire logic ext_clock_in, // Clock input pin level
    output logic sys_clk_r, // Selected system clock
    output logic ref_clk_o_r, // Reference clock pin data
    output logic ref_clk_oe_n_r, // Reference pin enable, low drives
    output logic pin_gpio_free_r, // Clock input pin free for I/O
    output logic hf_sec_start_r, // Start secondary clock
    output logic hf_pri_start_r, // Start primary clock
    output logic irq_r // Level interrupt
);
    import ofsc_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_m, rst_q;

    // Two-stage release keeps deassertion clean
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    // Address match, used by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ************************************************************
    // Control registers
    // ************************************************************
    logic roe_r, roe_nxt;
    logic [2:0] fsel_r, fsel_nxt;
    logic ext_r, ext_nxt;
    logic [2:0] irq_en_r, irq_en_nxt;

    // Software writes
    always_comb begin
        roe_nxt = roe_r;
        fsel_nxt = fsel_r;
        ext_nxt = ext_r;
        irq_en_nxt = irq_en_r;
        if (bus.wr) begin
            if (hit(bus.addr, `OFSC_REFCLK_ADDR)) begin
                roe_nxt = bus.wdata[`OFSC_ROE_BIT]; // [R1]
            end
            if (hit(bus.addr, `OFSC_OSC_ADDR)) begin
                fsel_nxt = bus.wdata[`OFSC_FSEL_MSB:`OFSC_FSEL_LSB]; // [R2]
            end
            if (hit(bus.addr, `OFSC_CFG_ADDR)) begin
                ext_nxt = bus.wdata[`OFSC_EXT_BIT]; // [R9]
            end
            if (hit(bus.addr, `OFSC_IRQ_EN_ADDR)) begin
                irq_en_nxt = bus.wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            roe_r <= `OFSC_ROE_RST; // [R12]
            fsel_r <= `OFSC_FSEL_RST; // [R3]
            ext_r <= `OFSC_EXT_RST;
            irq_en_r <= 3'h0;
        end else begin
            roe_r <= roe_nxt;
            fsel_r <= fsel_nxt;
            ext_r <= ext_nxt;
            irq_en_r <= irq_en_nxt;
        end
    end

    // ************************************************************
    // Oscillator start-up sequence and flags
    // ************************************************************
    ofsc_hf_st_t st_r, st_nxt;
    logic hf_rdy_r, hf_rdy_nxt;
    logic lf_rdy_r, lf_rdy_nxt;
    logic hf_stb_r, hf_stb_nxt;

    // Secondary first; primary only once secondary is ready
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            OFSC_ST_IDLE: st_nxt = OFSC_ST_SEC; // [R10]
            OFSC_ST_SEC: if (osc.hf_sec_ready) st_nxt = OFSC_ST_PRI; // [R10]
            OFSC_ST_PRI: if (osc.hf_pri_stable) st_nxt = OFSC_ST_RUN;
            OFSC_ST_RUN: st_nxt = OFSC_ST_RUN;
        endcase
        hf_rdy_nxt = osc.hf_sec_ready && (st_r != OFSC_ST_IDLE); // [R4]
        lf_rdy_nxt = osc.lf_ready; // [R5]
        // Stable is ignored until the primary clock was started
        hf_stb_nxt = osc.hf_pri_stable && st_r[1]; // [R6]
    end

    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            st_r <= OFSC_ST_IDLE;
            hf_rdy_r <= 1'b0; // [R12]
            lf_rdy_r <= 1'b0;
            hf_stb_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            hf_rdy_r <= hf_rdy_nxt;
            lf_rdy_r <= lf_rdy_nxt;
            hf_stb_r <= hf_stb_nxt;
        end
    end

    // ************************************************************
    // Divider and clock selection
    // ************************************************************
    logic hf_q_r, hf_q_nxt;
    logic [5:0] div_r, div_nxt;
    logic sel_clk_nxt, sys_nxt, ref_o_nxt, oe_n_nxt, free_nxt;
    logic [2:0] tap;

    // Free-running divider; a rate change only moves the tap
    always_comb begin
        hf_q_nxt = hf_osc_in;
        div_nxt = div_r;
        if (hf_osc_in && !hf_q_r) begin
            div_nxt = div_r + 6'h01;
        end
        tap = `OFSC_FSEL_RST - fsel_r;
        if (fsel_r == `OFSC_FSEL_16M) begin
            sel_clk_nxt = hf_osc_in; // [R2]
        end else if (fsel_r == `OFSC_FSEL_LF) begin
            sel_clk_nxt = lf_osc_in; // [R2]
        end else begin
            sel_clk_nxt = div_r[tap]; // [R11]
        end
        // No high-frequency output before the secondary clock is started
        if (st_r == OFSC_ST_IDLE && fsel_r != `OFSC_FSEL_LF) begin
            sel_clk_nxt = 1'b0;
        end
        sys_nxt = ext_r ? ext_clock_in : sel_clk_nxt; // [R8]
        free_nxt = !ext_r; // [R9]
        ref_o_nxt = sys_nxt && roe_r; // [R1]
        oe_n_nxt = !roe_r; // [R1]
    end

    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            hf_q_r <= 1'b0;
            div_r <= 6'h00;
            sys_clk_r <= 1'b0;
            ref_clk_o_r <= 1'b0;
            ref_clk_oe_n_r <= 1'b1;
            pin_gpio_free_r <= 1'b1;
            hf_sec_start_r <= 1'b0;
            hf_pri_start_r <= 1'b0;
        end else begin
            hf_q_r <= hf_q_nxt;
            div_r <= div_nxt;
            sys_clk_r <= sys_nxt;
            ref_clk_o_r <= ref_o_nxt;
            ref_clk_oe_n_r <= oe_n_nxt;
            pin_gpio_free_r <= free_nxt;
            hf_sec_start_r <= (st_nxt != OFSC_ST_IDLE);
            hf_pri_start_r <= st_nxt[1];
        end
    end

    // ************************************************************
    // Interrupt flags and read data
    // ************************************************************
    logic [2:0] evt, flag_prev_r, irq_st_r, irq_st_nxt;
    logic irq_nxt;
    logic [7:0] rd_nxt;

    assign evt = {hf_stb_r, lf_rdy_r, hf_rdy_r} & ~flag_prev_r;

    // Rising flags are sticky; a set in the clear cycle wins
    generate
        for (genvar i = 0; i < 3; i++) begin : g_evt
            always_comb begin
                irq_st_nxt[i] = irq_st_r[i];
                if (bus.wr && hit(bus.addr, `OFSC_IRQ_CLR_ADDR) && bus.wdata[i]) begin
                    irq_st_nxt[i] = 1'b0;
                end
                if (evt[i]) begin
                    irq_st_nxt[i] = 1'b1;
                end
            end
        end
    endgenerate

    // Reads return zero for unimplemented bits and unmapped offsets
    always_comb begin
        irq_nxt = |(irq_st_nxt & irq_en_nxt);
        rd_nxt = 8'h00;
        if (bus.rd) begin
            if (hit(bus.addr, `OFSC_REFCLK_ADDR)) begin
                rd_nxt[`OFSC_ROE_BIT] = roe_r; // [R7]
            end
            if (hit(bus.addr, `OFSC_OSC_ADDR)) begin
                rd_nxt[`OFSC_FSEL_MSB:`OFSC_FSEL_LSB] = fsel_r; // [R7]
                rd_nxt[`OFSC_HFR_BIT] = hf_rdy_r; // [R4]
                rd_nxt[`OFSC_LFR_BIT] = lf_rdy_r; // [R5]
                rd_nxt[`OFSC_HFS_BIT] = hf_stb_r; // [R6]
            end
            if (hit(bus.addr, `OFSC_CFG_ADDR)) begin
                rd_nxt[`OFSC_EXT_BIT] = ext_r;
            end
            if (hit(bus.addr, `OFSC_IRQ_STAT_ADDR)) begin
                rd_nxt[2:0] = irq_st_r;
            end
            if (hit(bus.addr, `OFSC_IRQ_EN_ADDR)) begin
                rd_nxt[2:0] = irq_en_r;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            flag_prev_r <= 3'h0;
            irq_st_r <= 3'h0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            flag_prev_r <= {hf_stb_r, lf_rdy_r, hf_rdy_r};
            irq_st_r <= irq_st_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rd_nxt;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_q);

    chk_ref_drive: assert property ($past(roe_r) // [R1]
        |-> ref_clk_o_r == sys_clk_r && !ref_clk_oe_n_r)
        else $error("reference pin not driven with system clock");
    chk_ref_off: assert property (!roe_r |=> !ref_clk_o_r && ref_clk_oe_n_r) // [R1]
        else $error("reference pin driven while disabled");
    chk_fsel_write: assert property (bus.wr && bus.addr == `OFSC_OSC_ADDR // [R2]
        |=> fsel_r == $past(bus.wdata[6:4]))
        else $error("select field did not take written code");
    chk_lf_pick: assert property (!ext_r && fsel_r == `OFSC_FSEL_LF // [R2]
        |=> sys_clk_r == $past(lf_osc_in))
        else $error("low-frequency source not selected");
    chk_hf_pick: assert property (!ext_r && fsel_r == 3'h7 && st_r != OFSC_ST_IDLE // [R2] [R11]
        |=> sys_clk_r == $past(hf_osc_in))
        else $error("16 MHz output not selected");
    chk_reset_vals: assert property ($rose(rst_q) |-> fsel_r == 3'h6 && !roe_r // [R3] [R12]
        && !hf_rdy_r && !lf_rdy_r && !hf_stb_r)
        else $error("wrong values after reset");
    chk_ext_pick: assert property (ext_r |=> sys_clk_r == $past(ext_clock_in) // [R8] [R9]
        && !pin_gpio_free_r)
        else $error("external clock not used");
    chk_gpio_free: assert property (!ext_r |=> pin_gpio_free_r) // [R9]
        else $error("clock input pin not released");
    chk_rd_zero: assert property (bus.rd |=> rdata_r[7] == 1'b0 // [R7]
        && ($past(bus.addr) != 8'h01 || rdata_r[2] == 1'b0))
        else $error("unimplemented bit read as one");
    // Reference register has one live bit; the rest must read zero
    chk_ref_zero: assert property (bus.rd && bus.addr == `OFSC_REFCLK_ADDR // [R7]
        |=> (rdata_r & 8'hBF) == 8'h00)
        else $error("reference register reads unimplemented bit");
    // First edge out of reset skipped: flags are still held cleared there
    chk_flags: assert property ($past(rst_q) |-> lf_rdy_r == $past(osc.lf_ready) // [R4] [R5]
        && (hf_rdy_r == ($past(osc.hf_sec_ready) && $past(st_r) != OFSC_ST_IDLE)))
        else $error("ready flag does not follow oscillator");
    chk_hf_order: assert property (hf_stb_r |-> hf_pri_start_r && hf_sec_start_r) // [R6] [R10]
        else $error("stable before primary start");

    cov_rate_change: cover property (bus.wr && bus.addr == `OFSC_OSC_ADDR ##1 $changed(fsel_r));
    cov_run: cover property (st_r == OFSC_ST_PRI ##1 st_r == OFSC_ST_RUN);
    cov_ext: cover property ($rose(ext_r));
    cov_irq: cover property ($rose(irq_r));

endmodule : ofsc_ctrl

// [testbench/ofsc_ext_src.sv]
// ************************************************************
// External clock source on the clock input pin
// ************************************************************
module ofsc_ext_src (
    input wire logic core_clk, // Bench clock
    input wire logic run, // Source running
    input wire logic [2:0] half, // Half period in cycles
    output logic ext_clk // Logic-level clock to the pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r = 3'h0;
    logic clk_r = 1'b0; // Known level before the first edge

    assign ext_clk = clk_r;

    // Logic-level clock, held low while stopped
    always @(posedge core_clk) begin
        if (!run) begin
            cnt_r <= 3'h0;
            clk_r <= 1'b0;
        end else if (cnt_r + 3'h1 >= half) begin
            cnt_r <= 3'h0;
            clk_r <= ~clk_r;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule : ofsc_ext_src

// [testbench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ofsc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    ofsc_bus_req_t bus = '0;
    ofsc_osc_stat_t osc = '0;
    logic hf_osc_in = 1'b0;
    logic lf_osc_in = 1'b0;
    logic ext_clock_in;
    logic [7:0] rdata_r;
    logic sys_clk_r, ref_clk_o_r, ref_clk_oe_n_r, pin_gpio_free_r;
    logic hf_sec_start_r, hf_pri_start_r, irq_r;
    logic run = 1'b0;
    logic [2:0] half = 3'h1;
    logic hf_d, lf_d, ex_d, hf_dd;
    logic dv_on = 1'b0;
    logic dv_prev;
    int dv_st = 0, dv_n = 0, dv_want = 1;
    logic [1:0] mode = 2'h0;
    logic roe_on = 1'b0;
    logic [7:0] d;
    int error_cnt = 0;
    int checked = 0;

    ofsc_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata_r(rdata_r),
        .osc(osc), .hf_osc_in(hf_osc_in), .lf_osc_in(lf_osc_in),
        .ext_clock_in(ext_clock_in), .sys_clk_r(sys_clk_r), .ref_clk_o_r(ref_clk_o_r),
        .ref_clk_oe_n_r(ref_clk_oe_n_r), .pin_gpio_free_r(pin_gpio_free_r),
        .hf_sec_start_r(hf_sec_start_r), .hf_pri_start_r(hf_pri_start_r), .irq_r(irq_r));
    ofsc_ext_src src_i (.core_clk(core_clk), .run(run), .half(half), .ext_clk(ext_clock_in));

    // 20 MHz clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // Expectations and bus tasks
    // ************************************************************
    function automatic logic [7:0] osc_exp(logic [2:0] f, logic hr, logic lr, logic hs);
        return {1'b0, f, hr, 1'b0, lr, hs};
    endfunction : osc_exp

    function automatic logic src_exp(logic [1:0] m);
        return (m == 2'h1) ? hf_d : (m == 2'h2) ? lf_d : ex_d;
    endfunction : src_exp

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk(rdata_r, exp);
    endtask : rd_chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // Random oscillator waveforms; keep what the design samples
    always @(posedge core_clk) begin
        hf_d <= hf_osc_in;
        hf_dd <= hf_d;
        lf_d <= lf_osc_in;
        ex_d <= ext_clock_in;
        hf_osc_in <= 1'($urandom);
        lf_osc_in <= 1'($urandom);
    end

    // Selected clock and reference pin, checked mid-cycle
    always @(negedge core_clk) begin
        if (mode != 2'h0) begin
            chk({7'h0, sys_clk_r}, {7'h0, src_exp(mode)});
            if (roe_on) begin
                chk({7'h0, ref_clk_o_r}, {7'h0, sys_clk_r});
            end
        end
    end

    // Divided rates: input rising edges between two output changes
    always @(negedge core_clk) begin
        if (!dv_on) begin
            dv_st = 0;
        end else if (dv_st == 0) begin
            dv_prev = sys_clk_r;
            dv_st = 1;
        end else begin
            if (hf_d && !hf_dd) begin
                dv_n++;
            end
            if (sys_clk_r !== dv_prev) begin
                if (dv_st == 2) begin
                    chk(8'(dv_n), 8'(dv_want));
                end
                dv_st = 2;
                dv_n = 0;
            end
            dv_prev = sys_clk_r;
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int n;
        void'($urandom(32'hF9D1));
        cyc(12);
        rst_n <= 1'b1;
        cyc(3);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, osc_exp(3'h6, 1'b0, 1'b0, 1'b0));
        chk({7'h0, ref_clk_oe_n_r}, 8'h01);
        // Stable reported before ready must not show
        osc.hf_pri_stable <= 1'b1;
        cyc(3);
        rd_chk(8'h01, osc_exp(3'h6, 1'b0, 1'b0, 1'b0));
        chk({6'h0, hf_sec_start_r, hf_pri_start_r}, 8'h02);
        osc.hf_sec_ready <= 1'b1;
        n = 0;
        while (hf_pri_start_r !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        // A hang is counted; the closing report still follows
        if (n >= 20) begin
            error_cnt++;
        end
        cyc(3);
        rd_chk(8'h01, osc_exp(3'h6, 1'b1, 1'b0, 1'b1));
        osc.lf_ready <= 1'b1;
        cyc(2);
        rd_chk(8'h01, osc_exp(3'h6, 1'b1, 1'b1, 1'b1));
        // Interrupt: masked, enabled, cleared
        rd_chk(8'h03, 8'h07);
        chk({7'h0, irq_r}, 8'h00);
        bus_wr(8'h05, 8'h07);
        cyc(2);
        chk({7'h0, irq_r}, 8'h01);
        bus_wr(8'h04, 8'h07);
        cyc(2);
        chk({7'h0, irq_r}, 8'h00);
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h04, 8'h00);
        bus_wr(8'h3C, 8'hFF);
        rd_chk(8'h3C, 8'h00);
        // Every select code, random filler in the other bits
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[6:4] = 3'(i);
            bus_wr(8'h01, d);
            rd_chk(8'h01, osc_exp(3'(i), 1'b1, 1'b1, 1'b1));
        end
        mode = 2'h1;
        d = 8'($urandom) | 8'h40;
        bus_wr(8'h00, d);
        rd_chk(8'h00, 8'h40);
        cyc(1);
        roe_on = 1'b1;
        chk({7'h0, ref_clk_oe_n_r}, 8'h00);
        cyc(20);
        roe_on = 1'b0;
        bus_wr(8'h00, d & 8'hBF);
        rd_chk(8'h00, 8'h00);
        chk({7'h0, ref_clk_oe_n_r}, 8'h01);
        mode = 2'h0;
        bus_wr(8'h01, 8'h00);
        cyc(3);
        mode = 2'h2;
        cyc(20);
        mode = 2'h0;
        // Each divided code: half period is a power of two input edges
        for (int c = 1; c < 7; c++) begin
            dv_on = 1'b0;
            bus_wr(8'h01, {1'b0, 3'(c), 4'h0});
            cyc(1);
            dv_want = 1 << (6 - c);
            dv_on = 1'b1;
            cyc(40 << (6 - c));
        end
        dv_on = 1'b0;
        bus_wr(8'h01, 8'h50);
        cyc(4);
        bus_wr(8'h01, 8'h70);
        cyc(1);
        mode = 2'h1;
        cyc(20);
        mode = 2'h0;
        // External clock mode with a random source rate
        run <= 1'b1;
        half <= 3'($urandom_range(4, 1));
        bus_wr(8'h02, 8'h01);
        cyc(3);
        chk({7'h0, pin_gpio_free_r}, 8'h00);
        mode = 2'h3;
        cyc(30);
        mode = 2'h0;
        bus_wr(8'h02, 8'h00);
        cyc(2);
        chk({7'h0, pin_gpio_free_r}, 8'h01);
        run <= 1'b0;
        // Second reset in mid-run
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        rd_chk(8'h00, 8'h00);
        chk({7'h0, ref_clk_oe_n_r}, 8'h01);
        rd_chk(8'h01, osc_exp(3'h6, 1'b1, 1'b1, 1'b1));
        report_and_stop;
    end
endmodule : tb
